// >>> logic/dclk_core.sv
// Implementation choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module dclk_core
    import dclk_pkg::*;
#(
    parameter int unsigned LOCK_CYCLES = DCLK_LOCK_CYCLES
) (
    // System
    input wire logic aclk,
    input wire logic aresetn,
    // Memory command pins from the controller
    input wire logic mem_clk,
    input wire logic mem_cke,
    input wire logic mem_odt,
    input wire logic [2:0] mem_cmd,
    input wire logic [1:0] mem_mr_sel,
    input wire logic [15:0] mem_addr,
    // Strobes and data feedback
    input wire logic upper_lane_strobe,
    input wire logic lower_lane_strobe,
    output logic [15:0] dq_o,
    output logic [15:0] dq_oe,
    output logic strobe_term_on,
    output logic dq_term_on,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    // Two-flop synchronisers for every pin
    localparam int unsigned SW = 26;
    logic [SW-1:0] pin_raw, s1_q, s2_q;
    assign pin_raw = {mem_clk, mem_cke, mem_odt, mem_cmd, mem_mr_sel, mem_addr,
                      upper_lane_strobe, lower_lane_strobe};
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= '0;
            s2_q <= '0;
        end else begin
            s1_q <= pin_raw;
            s2_q <= s1_q;
        end
    end
    logic ck_s, cke_s, odt_s, ustb_s, lstb_s;
    logic [2:0] cmd_s;
    logic [1:0] mrsel_s;
    logic [15:0] addr_s;
    assign {ck_s, cke_s, odt_s, cmd_s, mrsel_s, addr_s, ustb_s, lstb_s} = s2_q;

    // Edge history of clock and strobes
    logic ck_prev_q, ustb_prev_q, lstb_prev_q;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ck_prev_q <= 1'b0;
            ustb_prev_q <= 1'b0;
            lstb_prev_q <= 1'b0;
        end else begin
            ck_prev_q <= ck_s;
            ustb_prev_q <= ustb_s;
            lstb_prev_q <= lstb_s;
        end
    end
    logic ck_rise, ustb_rise, lstb_rise;
    assign ck_rise = ck_s && !ck_prev_q;
    assign ustb_rise = ustb_s && !ustb_prev_q;
    assign lstb_rise = lstb_s && !lstb_prev_q;

    // Mode registers, state and counters
    dclk_state_t st_q, st_d;
    logic [15:0] ext1_q, ext1_d, base_q, base_d;
    logic [15:0] cnt_q, cnt_d;
    logic [3:0] mrd_q, mrd_d;
    logic [7:0] cmd_cnt_q, cmd_cnt_d;
    logic [7:0] viol_cnt_q, viol_cnt_d;
    logic [15:0] lock_cfg_q, lock_cfg_d;
    logic freq_ok_q, freq_ok_d;
    logic dll_locked_q, dll_locked_d;
    logic [7:0] upper_fb_q, upper_fb_d, lower_fb_q, lower_fb_d;
    logic cmd_valid, is_mrs, leveling;
    logic [15:0] lock_target;
    assign cmd_valid = ck_rise && cke_s;
    assign is_mrs = cmd_valid && cmd_s == DCLK_CMD_MRS;
    assign leveling = ext1_q[DCLK_LEVEL_EN_POS];
    assign lock_target = lock_cfg_q;

    always_comb begin
        st_d = st_q;
        ext1_d = ext1_q;
        base_d = base_q;
        cnt_d = cnt_q;
        mrd_d = mrd_q;
        cmd_cnt_d = cmd_cnt_q;
        viol_cnt_d = viol_cnt_q;
        freq_ok_d = freq_ok_q;
        dll_locked_d = dll_locked_q;
        upper_fb_d = upper_fb_q;
        lower_fb_d = lower_fb_q;
        // Spacing counts real clock edges only
        if (ck_rise && mrd_q != 4'h0) begin
            mrd_d = mrd_q - 4'h1;
        end
        if (is_mrs) begin
            cmd_cnt_d = cmd_cnt_q + 8'h01;
            if (mrd_q != 4'h0) begin
                viol_cnt_d = viol_cnt_q + 8'h01;
            end else begin
                mrd_d = DCLK_MODE_SET_SPACING - 4'h1;
                if (mrsel_s == DCLK_MR_EXT1) begin
                    ext1_d = addr_s;
                    if (addr_s[DCLK_DLL_DISABLE_POS]) begin
                        dll_locked_d = 1'b0;
                    end
                end else if (mrsel_s == DCLK_MR_BASE) begin
                    base_d = addr_s;
                    if (addr_s[DCLK_DLL_RESET_POS] && !ext1_q[DCLK_DLL_DISABLE_POS]) begin
                        st_d = DCLK_RELOCK;
                        cnt_d = '0;
                        dll_locked_d = 1'b0;
                    end
                end
            end
        end else if (cmd_valid && leveling && cmd_s != DCLK_CMD_NOP) begin
            viol_cnt_d = viol_cnt_q + 8'h01;
        end
        unique case (st_q)
            DCLK_ACTIVE: begin
                if (ck_rise && !cke_s) begin
                    cnt_d = '0;
                    freq_ok_d = 1'b0;
                    st_d = (cmd_s == DCLK_CMD_REF) ? DCLK_SELF_REFRESH : DCLK_POWER_DOWN;
                end
            end
            DCLK_SELF_REFRESH, DCLK_POWER_DOWN: begin
                // Clock is a don't care once hold time has passed
                if (cnt_q < 16'(DCLK_HOLD_CYC)) begin
                    cnt_d = cnt_q + 16'h0001;
                end else begin
                    freq_ok_d = 1'b1;
                end
                if (st_q == DCLK_POWER_DOWN && ck_rise && odt_s) begin
                    viol_cnt_d = viol_cnt_q + 8'h01;
                end
                if (cke_s && ck_rise) begin
                    freq_ok_d = 1'b0;
                    dll_locked_d = (st_q == DCLK_POWER_DOWN) ? 1'b0 : dll_locked_q;
                    cnt_d = '0;
                    st_d = DCLK_EXIT_WAIT;
                end
            end
            DCLK_EXIT_WAIT: begin
                if (cnt_q < 16'(DCLK_EXIT_CYC)) begin
                    cnt_d = cnt_q + 16'h0001;
                end else if (st_d == DCLK_EXIT_WAIT) begin
                    st_d = DCLK_ACTIVE;
                end
            end
            DCLK_RELOCK: begin
                if (ck_rise && (!cke_s || odt_s)) begin
                    viol_cnt_d = viol_cnt_q + 8'h01;
                end
                if (ck_rise) begin
                    cnt_d = cnt_q + 16'h0001;
                end
                if (cnt_q >= lock_target) begin
                    dll_locked_d = 1'b1;
                    st_d = DCLK_ACTIVE;
                end
            end
            default: st_d = DCLK_ACTIVE;
        endcase
        // Leveling feedback: sample clock on each strobe rise
        if (leveling && ustb_rise) begin
            upper_fb_d = {8{ck_s}};
        end
        if (leveling && lstb_rise) begin
            lower_fb_d = {8{ck_s}};
        end
    end

    // AXI4-Lite
    logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d, bvalid_q, bvalid_d;
    logic rvalid_q, rvalid_d;
    logic [11:0] awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [15:0] lock_wr;
    always_comb begin
        aw_hold_d = aw_hold_q;
        w_hold_d = w_hold_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        lock_cfg_d = lock_cfg_q;
        lock_wr = lock_cfg_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_d = 1'b1;
            if (s_axi_wstrb[0]) lock_wr[7:0] = s_axi_wdata[7:0];
            if (s_axi_wstrb[1]) lock_wr[15:8] = s_axi_wdata[15:8];
            wdata_d = {16'h0000, lock_wr};
        end
        if (aw_hold_q && w_hold_q && !bvalid_q) begin
            aw_hold_d = 1'b0;
            w_hold_d = 1'b0;
            bvalid_d = 1'b1;
            if (awaddr_q == DCLK_AXI_LOCKCFG) begin
                lock_cfg_d = wdata_q[15:0];
                bresp_d = 2'b00;
            end else begin
                bresp_d = 2'b10;
            end
        end
        if (bvalid_q && s_axi_bready) bvalid_d = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = 2'b00;
            unique case (s_axi_araddr)
                DCLK_AXI_STATUS: rdata_d = {viol_cnt_q, cmd_cnt_q, 8'h00,
                                            3'h0, dll_locked_q, freq_ok_q, st_q};
                DCLK_AXI_EXT1: rdata_d = {16'h0000, ext1_q};
                DCLK_AXI_BASE: rdata_d = {16'h0000, base_q};
                DCLK_AXI_LOCKCFG: rdata_d = {16'h0000, lock_cfg_q};
                default: begin
                    rdata_d = 32'h00000000;
                    rresp_d = 2'b10;
                end
            endcase
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
    end
    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready = !w_hold_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_q <= DCLK_ACTIVE;
            ext1_q <= DCLK_EXT1_RESET;
            base_q <= 16'h0000;
            cnt_q <= 16'h0000;
            mrd_q <= 4'h0;
            cmd_cnt_q <= 8'h00;
            viol_cnt_q <= 8'h00;
            freq_ok_q <= 1'b0;
            dll_locked_q <= 1'b1;
            upper_fb_q <= 8'h00;
            lower_fb_q <= 8'h00;
            lock_cfg_q <= 16'(LOCK_CYCLES);
            aw_hold_q <= 1'b0;
            w_hold_q <= 1'b0;
            awaddr_q <= 12'h000;
            wdata_q <= 32'h00000000;
            bvalid_q <= 1'b0;
            bresp_q <= 2'b00;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h00000000;
            rresp_q <= 2'b00;
        end else begin
            st_q <= st_d;
            ext1_q <= ext1_d;
            base_q <= base_d;
            cnt_q <= cnt_d;
            mrd_q <= mrd_d;
            cmd_cnt_q <= cmd_cnt_d;
            viol_cnt_q <= viol_cnt_d;
            freq_ok_q <= freq_ok_d;
            dll_locked_q <= dll_locked_d;
            upper_fb_q <= upper_fb_d;
            lower_fb_q <= lower_fb_d;
            lock_cfg_q <= lock_cfg_d;
            aw_hold_q <= aw_hold_d;
            w_hold_q <= w_hold_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    // Feedback drive and termination
    assign dq_o = {upper_fb_q, lower_fb_q};
    assign dq_oe = {16{leveling}};
    assign strobe_term_on = leveling && odt_s;
    assign dq_term_on = !leveling && odt_s && dll_locked_q;
endmodule

// >>> logic/dclk_pkg.sv
package dclk_pkg;
    localparam int unsigned DCLK_CLK_PERIOD_PS = 10000;
    localparam logic [3:0] DCLK_MODE_SET_SPACING = 4'h4;
    localparam int unsigned DCLK_HOLD_AFTER_ENTRY_NS = 10;
    localparam int unsigned DCLK_EXIT_TIME_NS = 24;
    localparam int unsigned DCLK_LOCK_CYCLES = 512;
    localparam int unsigned DCLK_HOLD_CYC =
        (DCLK_HOLD_AFTER_ENTRY_NS * 1000 + DCLK_CLK_PERIOD_PS - 1) / DCLK_CLK_PERIOD_PS;
    localparam int unsigned DCLK_EXIT_CYC =
        (DCLK_EXIT_TIME_NS * 1000 + DCLK_CLK_PERIOD_PS - 1) / DCLK_CLK_PERIOD_PS;
    localparam int unsigned DCLK_DLL_DISABLE_POS = 0;
    localparam int unsigned DCLK_LEVEL_EN_POS = 7;
    localparam int unsigned DCLK_DLL_RESET_POS = 8;
    localparam logic [2:0] DCLK_CMD_MRS = 3'h0;
    localparam logic [2:0] DCLK_CMD_REF = 3'h1;
    localparam logic [2:0] DCLK_CMD_NOP = 3'h7;
    localparam logic [1:0] DCLK_MR_BASE = 2'h0;
    localparam logic [1:0] DCLK_MR_EXT1 = 2'h1;
    localparam logic [15:0] DCLK_EXT1_RESET = 16'h0000;
    localparam logic [11:0] DCLK_AXI_STATUS = 12'h000;
    localparam logic [11:0] DCLK_AXI_EXT1 = 12'h004;
    localparam logic [11:0] DCLK_AXI_BASE = 12'h008;
    localparam logic [11:0] DCLK_AXI_LOCKCFG = 12'h00C;
    typedef enum logic [2:0] {
        DCLK_ACTIVE = 3'b000,
        DCLK_SELF_REFRESH = 3'b001,
        DCLK_POWER_DOWN = 3'b010,
        DCLK_EXIT_WAIT = 3'b011,
        DCLK_RELOCK = 3'b100
    } dclk_state_t;
endpackage

// >>> tb/dclk_properties.sv
`timescale 1ns/1ps
module dclk_properties (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins
    input wire logic mem_odt,
    input wire logic upper_lane_strobe,
    input wire logic [15:0] dq_o,
    input wire logic [15:0] dq_oe,
    input wire logic strobe_term_on,
    input wire logic dq_term_on,
    // Register bus
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic stb_q, stb_d;
    logic [3:0] age_q, age_d;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Cycles since the last upper strobe rise, saturating
    always_comb begin
        stb_d = upper_lane_strobe;
        age_d = (upper_lane_strobe && !stb_q) ? 4'h0 : age_q + {3'h0, age_q != 4'hF};
    end
    always_ff @(posedge aclk) begin
        stb_q <= stb_d;
        age_q <= aresetn ? age_d : 4'hF;
    end
    a_oe_whole: assert property (dq_oe == 16'h0000 || dq_oe == 16'hFFFF)
        else $error("dq_oe not uniform");
    a_upper_byte: assert property (&dq_o[15:8] || dq_o[15:8] == 8'h00)
        else $error("upper feedback byte mixed");
    a_lower_byte: assert property (&dq_o[7:0] || dq_o[7:0] == 8'h00)
        else $error("lower feedback byte mixed");
    a_fb_cause: assert property ($changed(dq_o[15:8]) && dq_oe[15] && $past(dq_oe[15])
        |-> age_q < 4'h8) else $error("feedback moved without strobe");
    a_dq_term_lvl: assert property (dq_oe[0] |-> !dq_term_on)
        else $error("data termination on in leveling");
    a_strobe_lvl: assert property (strobe_term_on |-> dq_oe[0])
        else $error("strobe termination outside leveling");
    a_odt_on_lvl: assert property ((dq_oe[0] && mem_odt) [*4] |-> strobe_term_on)
        else $error("strobe termination missing");
    a_odt_off: assert property ((!mem_odt) [*4] |-> !strobe_term_on && !dq_term_on)
        else $error("termination on with odt low");
    a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
        && $stable(s_axi_bresp)) else $error("write response dropped");
    a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
        && $stable(s_axi_rdata)) else $error("read data dropped");
    a_err_data: assert property (s_axi_rvalid && s_axi_rresp == 2'h2 |-> s_axi_rdata == 32'h0)
        else $error("error read with data");
    c_level: cover property ($rose(dq_oe[0]));
    c_fb_one: cover property ($rose(dq_o[15]));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule

// >>> tb/dclk_ctrl_model.sv
`timescale 1ns/1ps
module dclk_ctrl_model
    import dclk_pkg::*;
(
    // Clock and command pins
    output logic mem_clk,
    output logic mem_cke,
    output logic mem_odt,
    output logic [2:0] mem_cmd,
    output logic [1:0] mem_mr_sel,
    output logic [15:0] mem_addr,
    // Write strobes
    output logic upper_lane_strobe,
    output logic lower_lane_strobe
);
    // Entry hold time rounded up to whole 125 ns link cycles
    localparam int unsigned HOLD_CK = (DCLK_HOLD_AFTER_ENTRY_NS * 8 + 999) / 1000;
    logic run = 1'b1;
    initial begin
        mem_clk = 1'b0;
        mem_cke = 1'b1;
        mem_odt = 1'b0;
        mem_cmd = DCLK_CMD_NOP;
        mem_mr_sel = 2'h0;
        mem_addr = 16'h0000;
        {upper_lane_strobe, lower_lane_strobe} = 2'h0;
    end
    // Stopping always parks the clock low
    // Offset keeps pin changes clear of the system clock edges
    initial begin
        #1;
        forever begin
            #62.5;
            if (run || mem_clk) mem_clk = !mem_clk;
        end
    end
    task automatic odt(input bit v);
        @(negedge mem_clk);
        mem_odt = v;
    endtask
    // Only nops follow a command, also in leveling
    task automatic issue(input logic [2:0] c, input logic [1:0] s, input logic [15:0] a,
                         input int gap);
        @(negedge mem_clk);
        mem_cmd = c;
        mem_mr_sel = s;
        mem_addr = a;
        @(negedge mem_clk);
        mem_cmd = DCLK_CMD_NOP;
        mem_addr = ~a;
        repeat (gap) @(negedge mem_clk);
    endtask
    task automatic strobe(input bit up, input logic [7:0] ph);
        @(posedge mem_clk);
        #(ph);
        {upper_lane_strobe, lower_lane_strobe} = {up, !up};
        #30;
        {upper_lane_strobe, lower_lane_strobe} = 2'h0;
    endtask
    task automatic lp_enter(input bit sr);
        @(negedge mem_clk);
        mem_odt = 1'b0;
        mem_cke = 1'b0;
        mem_cmd = sr ? DCLK_CMD_REF : DCLK_CMD_NOP;
        @(negedge mem_clk);
        mem_cmd = DCLK_CMD_NOP;
        repeat (HOLD_CK + 1) @(negedge mem_clk);
    endtask
    task automatic lp_leave;
        run = 1'b0;
        #500;
        run = 1'b1;
        repeat (4) @(negedge mem_clk);
        mem_cke = 1'b1;
    endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    import dclk_pkg::*;
    typedef struct packed {
        logic wr;
        logic [11:0] a;
        logic [31:0] d;
        logic [1:0] r;
        logic [31:0] q;
    } dclk_row_t;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic mem_clk, mem_cke, mem_odt, upper_lane_strobe, lower_lane_strobe;
    logic strobe_term_on, dq_term_on, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [2:0] mem_cmd;
    logic [1:0] mem_mr_sel, s_axi_bresp, s_axi_rresp, rs;
    logic [15:0] mem_addr, dq_o, dq_oe;
    logic [31:0] s_axi_rdata, rq;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [11:0] s_axi_awaddr = 12'h0;
    logic [11:0] s_axi_araddr = 12'h0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    int err_total = 0;
    int checks_done = 0;
    logic [9:0] lv [6] = '{10'h31E, 10'h15A, 10'h393, 10'h21E, 10'h05A, 10'h293};
    dclk_row_t rows [10] = '{
        {1'b0, DCLK_AXI_STATUS, 32'h0, 2'h0, 32'h10},
        {1'b0, DCLK_AXI_EXT1, 32'h0, 2'h0, 32'h0},
        {1'b0, DCLK_AXI_BASE, 32'h0, 2'h0, 32'h0},
        {1'b0, DCLK_AXI_LOCKCFG, 32'h0, 2'h0, 32'h8},
        {1'b1, DCLK_AXI_LOCKCFG, 32'h28, 2'h0, 32'h0},
        {1'b0, DCLK_AXI_LOCKCFG, 32'h0, 2'h0, 32'h28},
        {1'b1, DCLK_AXI_EXT1, 32'h80, 2'h2, 32'h0},
        {1'b0, DCLK_AXI_EXT1, 32'h0, 2'h0, 32'h0},
        {1'b0, 12'h010, 32'h0, 2'h2, 32'h0},
        {1'b1, 12'h010, 32'h1, 2'h2, 32'h0}};

    always #5 aclk = !aclk;

    // Overall limit, counts as a mismatch
    initial begin
        repeat (50000) @(posedge aclk);
        chk(32'h1, 32'h0);
        test_done();
    end

    dclk_core #(.LOCK_CYCLES(8)) DUT (.*);
    dclk_ctrl_model PM (.*);

    task automatic test_done;
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic axi(input bit wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [1:0] r, output logic [31:0] q);
        int n;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= {wr, wr, !wr};
        n = 0;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            // Late ready lets the slave hold its answer
            if (n == 2) {s_axi_bready, s_axi_rready} <= {wr, !wr};
            n++;
        end while (!(s_axi_bvalid && s_axi_bready) && !(s_axi_rvalid && s_axi_rready) && n < 60);
        r = wr ? s_axi_bresp : s_axi_rresp;
        q = s_axi_rdata;
        {s_axi_bready, s_axi_rready} <= 2'h0;
        if (n == 60) chk(32'h1, 32'h0);
        if (n == 60) test_done();
    endtask
    task automatic poll(input logic [31:0] m, input logic [31:0] e);
        int n;
        n = 0;
        do begin
            axi(1'b0, DCLK_AXI_STATUS, 32'h0, rs, rq);
            n++;
        end while ((rq & m) !== e && n < 300);
        chk(rq & m, e);
        if (n == 300) test_done();
    endtask

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        foreach (rows[i]) begin
            axi(rows[i].wr, rows[i].a, rows[i].d, rs, rq);
            chk({30'h0, rs}, {30'h0, rows[i].r});
            if (!rows[i].wr) chk(rq, rows[i].q);
        end
        PM.issue(DCLK_CMD_MRS, DCLK_MR_EXT1, 16'h0000, 2);
        PM.issue(DCLK_CMD_MRS, DCLK_MR_BASE, 16'h0000, 1);
        PM.issue(DCLK_CMD_MRS, DCLK_MR_EXT1, 16'h0080, 2);
        poll(32'hFFFF_0000, 32'h0103_0000);
        chk({16'h0, dq_oe}, 32'h0);
        PM.issue(DCLK_CMD_MRS, DCLK_MR_EXT1, 16'h0080, 2);
        chk({16'h0, dq_oe}, 32'hFFFF);
        PM.odt(1'b1);
        repeat (6) @(posedge aclk);
        chk({30'h0, strobe_term_on, dq_term_on}, 32'h2);
        PM.odt(1'b0);
        foreach (lv[i]) begin
            PM.strobe(lv[i][8], lv[i][7:0]);
            repeat (8) @(posedge aclk);
            chk({24'h0, lv[i][8] ? dq_o[15:8] : dq_o[7:0]}, {24'h0, {8{lv[i][9]}}});
        end
        chk({16'h0, dq_o}, 32'hFFFF);
        // A non-nop command in leveling is counted as a violation
        PM.issue(DCLK_CMD_REF, DCLK_MR_BASE, 16'h0000, 2);
        poll(32'hFF00_0000, 32'h0200_0000);
        PM.issue(DCLK_CMD_MRS, DCLK_MR_EXT1, 16'h0000, 2);
        PM.odt(1'b1);
        repeat (6) @(posedge aclk);
        chk({15'h0, dq_oe[0], strobe_term_on, dq_term_on}, 32'h1);
        PM.lp_enter(1'b1);
        poll(32'hF, 32'h9);
        PM.lp_leave();
        poll(32'h7, 32'h0);
        PM.issue(DCLK_CMD_MRS, DCLK_MR_EXT1, 16'h0001, 2);
        poll(32'h10, 32'h0);
        PM.issue(DCLK_CMD_MRS, DCLK_MR_EXT1, 16'h0000, 2);
        PM.issue(DCLK_CMD_MRS, DCLK_MR_BASE, 16'h0100, 2);
        poll(32'h17, 32'h4);
        poll(32'h17, 32'h10);
        PM.lp_enter(1'b0);
        poll(32'hF, 32'hA);
        PM.lp_leave();
        poll(32'h7, 32'h0);
        // Reset in mid-run restores the defaults
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        axi(1'b0, DCLK_AXI_LOCKCFG, 32'h0, rs, rq);
        chk(rq, 32'h8);
        poll(32'hFFFF_FFFF, 32'h10);
        chk({16'h0, dq_o}, 32'h0);
        test_done();
    end
endmodule

bind dclk_core dclk_properties u_props (.*);
